/* include/rfsm_pkg.sv */
// Package of constants for the rate filter and self-test monitor
package rfsm_pkg;
  // Filter geometry
  localparam int          BOX_TAPS      = 64;
  localparam int          BOX_LOG2      = 6;
  localparam int          ST_DECIM      = 16;
  localparam int          ST_IIR_DEN    = 64;
  localparam int          ST_IIR_FB     = 63;
  localparam int          ST_IIR_SHIFT  = 6;
  localparam int          SAMPLE_W      = 16;
  localparam int          FIFO_DEPTH    = 4;
  // Resonator rate and self-test band edge
  localparam int          F0_HZ         = 15200;
  localparam int          ST_BW_DIV     = 8000;
  // Self-test deviation limits, arbitrary plain defaults
  localparam logic [15:0] ST_LIM_LOW    = 16'h0400;
  localparam logic [15:0] ST_LIM_HIGH   = 16'h0800;
  localparam logic [15:0] ST_NOMINAL    = 16'h1000;
  // Status field codes
  localparam logic [1:0]  STATUS_VALID  = 2'h1;
  localparam logic [1:0]  STATUS_BAD    = 2'h0;
  // Self-test read location
  localparam logic [8:0]  ADDR_SELFTEST = 9'h004;
endpackage

/* core/rfsm_fifo.sv */
`timescale 1ns/1ps
// Parameterised valid/ready FIFO for filtered rate words
module rfsm_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;

  // Handshakes and pointer updates
  always_comb begin
    o_in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    o_out_valid = (cnt_reg != '0);
    push        = i_in_valid && o_in_ready;
    pop         = o_out_valid && i_out_ready;
    wp_next     = push ? ((wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1)
                       : wp_reg;
    rp_next     = pop ? ((rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1)
                      : rp_reg;
    cnt_next    = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage has no reset; empty flag guards stale words
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_reg[wp_reg] <= i_in_data;
    end
  end

  assign o_out_data = mem_reg[rp_reg];
endmodule

/* core/rfsm_top.sv */
`timescale 1ns/1ps
// Rate low-pass filter with continuous self-test monitor
// Operation
// - Rate path: two cascaded 64-tap moving sums at resonator rate.
// - Self-test amplitude: y = (x + 63*y_prev)/64, every 16 samples.
// - Filtered self-test deviation compared continuously to fixed limits.
// - Above low limit only: fault flag set, status stays valid.
// - Above high limit: fault flag set, status forced invalid.
// - Self-test value returned on a read of the self-test location.
// - Stimulus alternates equal positive and negative deflections on each accepted sample.
// - Alternating stimulus cancels in the rate output filter.
// - Calibration offset, gain, self-test trim applied as given on input ports.
// - Results, status and fault bits leave on separate parallel outputs.
// - Answer to a read request comes on the following clock.
module rfsm_top
  import rfsm_pkg::*;
#(
  parameter int SW = SAMPLE_W
) (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rst,
  input  wire logic                 i_sample_valid,
  input  wire logic signed [SW-1:0] i_sample,
  input  wire logic signed [15:0]   i_cal_offset,
  input  wire logic        [15:0]   i_cal_gain,
  input  wire logic signed [15:0]   i_cal_st_trim,
  input  wire logic                 i_rd_req,
  input  wire logic        [8:0]    i_rd_addr,
  input  wire logic                 i_rate_ready,
  output logic                      o_stim_pos,
  output logic                      o_rate_valid,
  output logic signed [SW-1:0]      o_rate,
  output logic                      o_selftest_fault_flag,
  output logic [1:0]                o_sensor_status_field,
  output logic                      o_rd_valid,
  output logic [15:0]               o_rd_data,
  output logic                      o_sample_ready
);
  import rfsm_pkg::*;

  localparam int W1 = SW + BOX_LOG2;
  localparam int W2 = SW + 2*BOX_LOG2;

  logic signed [SW-1:0] s1_line [BOX_TAPS];
  logic signed [W1-1:0] s2_line [BOX_TAPS];
  logic signed [W1-1:0] acc1_reg, acc1_next;
  logic signed [W2-1:0] acc2_reg, acc2_next;
  logic [BOX_LOG2-1:0]  ptr_reg, ptr_next;
  logic signed [SW-1:0] cal_x;
  logic                 stim_reg, stim_next;
  logic                 full_reg, full_next;
  logic signed [SW-1:0] old1;
  logic signed [W1-1:0] old2;
  logic [3:0]           dec_reg, dec_next;
  logic signed [31:0]   dsum_reg, dsum_next;
  logic [15:0]          st_amp_reg, st_amp_next;
  logic [15:0]          st_dev;
  logic                 fault_reg, fault_next;
  logic [1:0]           status_reg, status_next;
  logic                 rd_v_reg, rd_v_next;
  logic [15:0]          rd_d_reg, rd_d_next;
  logic                 take, rate_push, fifo_ready;
  logic signed [SW-1:0] rate_word;

  // Calibrated sample: offset and Q8.8 gain
  function automatic logic signed [SW-1:0] calib(
    input logic signed [SW-1:0] x,
    input logic signed [15:0]   off,
    input logic        [15:0]   g);
    logic signed [SW+17:0] p;
    // Widen before subtracting so extreme offsets cannot wrap
    p = ((SW+18)'(x) - (SW+18)'(off)) * $signed({2'h0, g});
    return SW'(p >>> 8);
  endfunction

  function automatic logic [15:0] absdiff(input logic [15:0] a,
                                          input logic [15:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  // Stall sample intake when the output FIFO is full
  assign take           = i_sample_valid && fifo_ready;
  assign o_sample_ready = fifo_ready;
  assign cal_x          = calib(i_sample, i_cal_offset, i_cal_gain);

  // Moving sums and self-test bookkeeping
  always_comb begin
    acc1_next   = acc1_reg;
    acc2_next   = acc2_reg;
    ptr_next    = ptr_reg;
    stim_next   = stim_reg;
    dec_next    = dec_reg;
    dsum_next   = dsum_reg;
    st_amp_next = st_amp_reg;
    full_next   = full_reg;
    rate_push   = 1'b0;
    // Taps read as zero until the line has wrapped once
    old1        = full_reg ? s1_line[ptr_reg] : '0;
    old2        = full_reg ? s2_line[ptr_reg] : '0;
    if (take) begin
      // Running sum of last 64 inputs per stage
      acc1_next = acc1_reg + W1'(cal_x) - W1'(old1);
      acc2_next = acc2_reg + W2'(acc1_next) - W2'(old2);
      ptr_next  = ptr_reg + 1'b1;
      if (ptr_reg == BOX_LOG2'(BOX_TAPS-1)) begin
        full_next = 1'b1;
      end
      stim_next = ~stim_reg;
      rate_push = 1'b1;
      // Demodulate stimulus: +sample on positive, -sample on negative
      dsum_next = stim_reg ? dsum_reg + 32'(cal_x)
                           : dsum_reg - 32'(cal_x);
      dec_next  = dec_reg + 1'b1;
      if (dec_reg == 4'(ST_DECIM-1)) begin
        // Recursive filter at one sixteenth of sample rate
        st_amp_next = 16'((32'(dsum_next >>> 3) + 32'(i_cal_st_trim)
                    + ST_IIR_FB * 32'(st_amp_reg))
                    >>> ST_IIR_SHIFT);
        dsum_next   = '0;
      end
    end
  end

  // Delay lines have no reset; unwritten taps are masked by the
  // fill flag, so no unknown value reaches the sums
  always_ff @(posedge i_clk_sys) begin
    if (take) begin
      s1_line[ptr_reg] <= cal_x;
      s2_line[ptr_reg] <= acc1_next;
    end
  end

  // Odd/even sample alternation cancels the stimulus over 64 taps
  assign rate_word = SW'(acc2_reg >>> (2*BOX_LOG2));

  // Severity decision against fixed limits
  always_comb begin
    st_dev      = absdiff(st_amp_reg, ST_NOMINAL);
    fault_next  = (st_dev > ST_LIM_LOW);
    status_next = (st_dev > ST_LIM_HIGH) ? STATUS_BAD
                                         : STATUS_VALID;
    rd_v_next   = i_rd_req;
    rd_d_next   = rd_d_reg;
    if (i_rd_req) begin
      rd_d_next = (i_rd_addr == ADDR_SELFTEST) ? st_amp_reg
                                               : 16'h0000;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      acc1_reg   <= '0;
      acc2_reg   <= '0;
      ptr_reg    <= '0;
      stim_reg   <= 1'b1;
      full_reg   <= 1'b0;
      dec_reg    <= '0;
      dsum_reg   <= '0;
      st_amp_reg <= ST_NOMINAL;
      fault_reg  <= 1'b0;
      status_reg <= STATUS_VALID;
      rd_v_reg   <= 1'b0;
      rd_d_reg   <= '0;
    end else begin
      acc1_reg   <= acc1_next;
      acc2_reg   <= acc2_next;
      ptr_reg    <= ptr_next;
      stim_reg   <= stim_next;
      full_reg   <= full_next;
      dec_reg    <= dec_next;
      dsum_reg   <= dsum_next;
      st_amp_reg <= st_amp_next;
      fault_reg  <= fault_next;
      status_reg <= status_next;
      rd_v_reg   <= rd_v_next;
      rd_d_reg   <= rd_d_next;
    end
  end

  // Rate words buffered toward the o_rate valid/ready output
  rfsm_fifo #(
    .WIDTH (SW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .i_in_valid  (rate_push),
    .o_in_ready  (fifo_ready),
    .i_in_data   (rate_word),
    .o_out_valid (o_rate_valid),
    .i_out_ready (i_rate_ready),
    .o_out_data  (o_rate)
  );

  assign o_stim_pos            = stim_reg;
  assign o_selftest_fault_flag = fault_reg;
  assign o_sensor_status_field = status_reg;
  assign o_rd_valid            = rd_v_reg;
  assign o_rd_data             = rd_d_reg;

  // Checks
  sequence s_high_dev;
    st_dev > ST_LIM_HIGH;
  endsequence

  sequence s_low_dev;
    (st_dev > ST_LIM_LOW) && (st_dev <= ST_LIM_HIGH);
  endsequence

  sequence s_rd_self;
    i_rd_req && (i_rd_addr == ADDR_SELFTEST);
  endsequence

  sequence s_rd_other;
    i_rd_req && (i_rd_addr != ADDR_SELFTEST);
  endsequence

  // Severity decision lands one clock after the deviation is seen
  chk_high_forces_bad: assert property (@(posedge i_clk_sys)
    disable iff (i_rst) s_high_dev |=> (status_reg == STATUS_BAD)
    && fault_reg) else $error("high deviation not flagged");
  chk_low_keeps_valid: assert property (@(posedge i_clk_sys)
    disable iff (i_rst) s_low_dev
    |=> fault_reg && status_reg == STATUS_VALID)
    else $error("low deviation handled wrong");
  chk_ok_no_fault: assert property (@(posedge i_clk_sys)
    disable iff (i_rst) (st_dev <= ST_LIM_LOW) |=> !fault_reg)
    else $error("fault without deviation");
  chk_stim_toggles: assert property (@(posedge i_clk_sys)
    disable iff (i_rst) take |=> stim_reg != $past(stim_reg))
    else $error("stimulus did not alternate");
  chk_iir_hold: assert property (@(posedge i_clk_sys)
    disable iff (i_rst) !(take && dec_reg == 4'(ST_DECIM-1))
    |=> $stable(st_amp_reg)) else $error("filter moved off-tick");

  // Read answers: one registered pulse per request
  chk_rd_selftest: assert property (@(posedge i_clk_sys)
    disable iff (i_rst) s_rd_self
    |=> o_rd_valid && o_rd_data == $past(st_amp_reg))
    else $error("self-test read wrong");
  chk_rd_other_zero: assert property (@(posedge i_clk_sys)
    disable iff (i_rst) s_rd_other
    |=> o_rd_valid && o_rd_data == 16'h0000)
    else $error("other read not zero");
  chk_rd_one_pulse: assert property (@(posedge i_clk_sys)
    disable iff (i_rst) !i_rd_req |=> !o_rd_valid)
    else $error("read answer without request");

  // Delay line bookkeeping and rate path
  chk_ptr_steps: assert property (@(posedge i_clk_sys)
    disable iff (i_rst) take |=> ptr_reg == $past(ptr_reg) + 1'b1)
    else $error("delay pointer stuck");
  chk_fill_sets: assert property (@(posedge i_clk_sys)
    disable iff (i_rst) (take && ptr_reg == BOX_LOG2'(BOX_TAPS-1))
    |=> full_reg) else $error("tap line never marked full");
  chk_idle_rate: assert property (@(posedge i_clk_sys)
    disable iff (i_rst) !take |=> $stable(acc2_reg))
    else $error("rate sum moved without sample");
  chk_full_refuse: assert property (@(posedge i_clk_sys)
    disable iff (i_rst) !o_sample_ready |=> $stable(ptr_reg))
    else $error("sample taken while buffer full");
endmodule

/* test/rfsm_front_model.sv */
`timescale 1ns/1ps
// Front end model: demodulated samples with the self-test deflection
module rfsm_front_model (
  input  wire logic               i_clk_sys,
  input  wire logic               i_en,
  input  wire logic signed [15:0] i_base,
  input  wire logic signed [15:0] i_dev,
  input  wire logic               i_stim_pos,
  output logic                    o_valid,
  output logic signed [15:0]      o_sample
);
  // Quiet at time zero
  initial begin
    o_valid = 1'b0;
    o_sample = 16'h0000;
  end
  // Offer held steady until taken; polarity flips only on acceptance
  always @(negedge i_clk_sys) begin
    o_valid <= i_en;
    if (i_en) begin
      o_sample <= i_stim_pos ? i_base + i_dev : i_base - i_dev;
    end else begin
      o_sample <= ~o_sample; // Idle line must not look valid
    end
  end
endmodule

/* test/tb_rfsm_top.sv */
`timescale 1ns/1ps
// Self-checking bench for the rate filter and self-test monitor
module tb_rfsm_top;
  import rfsm_pkg::*;
  logic               clk_sys = 1'b0;
  logic               rst = 1'b1;
  logic               en = 1'b0;
  logic signed [15:0] base = 16'h0100;
  logic signed [15:0] dev = 16'h0000;
  logic signed [15:0] off = 16'h0000;
  logic        [15:0] gain = 16'h0100;
  logic signed [15:0] trim = 16'h0000;
  logic               rd_req = 1'b0;
  logic        [8:0]  rd_addr = 9'h000;
  logic               rate_ready = 1'b1;
  logic               stim_pos, s_valid, s_ready, rate_valid, fault, rd_valid;
  logic signed [15:0] sample, rate;
  logic        [1:0]  status;
  logic        [15:0] rd_data;
  int                 fails = 0;
  int                 checks = 0;
  // 25 MHz clock
  always #20 clk_sys = ~clk_sys;
  rfsm_front_model u_fe (.i_clk_sys(clk_sys), .i_en(en), .i_base(base),
    .i_dev(dev), .i_stim_pos(stim_pos), .o_valid(s_valid),
    .o_sample(sample));
  rfsm_top u_dut (.i_clk_sys(clk_sys), .i_rst(rst), .i_sample_valid(s_valid),
    .i_sample(sample), .i_cal_offset(off), .i_cal_gain(gain),
    .i_cal_st_trim(trim), .i_rd_req(rd_req), .i_rd_addr(rd_addr),
    .i_rate_ready(rate_ready), .o_stim_pos(stim_pos),
    .o_rate_valid(rate_valid), .o_rate(rate),
    .o_selftest_fault_flag(fault), .o_sensor_status_field(status),
    .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_sample_ready(s_ready));
  task automatic chk(input string       n,
                     input logic [15:0] e,
                     input logic [15:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report();
    if (fails == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Steady input long enough to flush both 64-deep sums
  task automatic t_rate(input logic [15:0] b, d, o, g, e);
    logic p;
    base <= b;
    dev  <= d;
    off  <= o;
    gain <= g;
    en   <= 1'b1;
    cyc(300);
    chk("rate_valid", 16'h0001, {15'h0, rate_valid});
    chk("rate", e, rate);
    p = stim_pos;
    cyc(1);
    chk("stim_pos", {15'h0, ~p}, {15'h0, stim_pos});
  endtask
  // Stall the far side until the buffer refuses, then drain it
  task automatic t_fifo();
    rate_ready <= 1'b0;
    cyc(10);
    chk("sample_ready", 16'h0000, {15'h0, s_ready});
    chk("rate_valid", 16'h0001, {15'h0, rate_valid});
    en         <= 1'b0;
    rate_ready <= 1'b1;
    cyc(10);
    chk("rate_valid", 16'h0000, {15'h0, rate_valid});
    chk("sample_ready", 16'h0001, {15'h0, s_ready});
  endtask
  task automatic rd(input logic [8:0] a, output logic [15:0] q);
    rd_req  <= 1'b1;
    rd_addr <= a;
    cyc(1);
    rd_req <= 1'b0;
    chk("rd_valid", 16'h0001, {15'h0, rd_valid});
    q = rd_data;
    cyc(1);
    chk("rd_valid", 16'h0000, {15'h0, rd_valid});
  endtask
  // Zero deflection: filtered amplitude settles at or just below the trim
  task automatic t_st(input logic [15:0] t, input logic f, logic [1:0] s);
    logic [15:0] q;
    base <= 16'h0100;
    dev  <= 16'h0000;
    off  <= 16'h0000;
    gain <= 16'h0100;
    trim <= t;
    en   <= 1'b1;
    cyc(5600);
    chk("fault", {15'h0, f}, {15'h0, fault});
    chk("status", {14'h0, s}, {14'h0, status});
    rd(ADDR_SELFTEST, q);
    checks++;
    if ($isunknown(q) || q > t || q + 16'h0040 <= t) begin
      fails++;
      $display("MISMATCH rd_data expected %h seen %h", t, q);
    end
    rd(9'h005, q);
    chk("rd_other", 16'h0000, q);
  endtask
  // Watchdog sized well past the expected run
  initial begin
    #2400000;
    fails++;
    final_report();
  end
  initial begin
    cyc(12);
    chk("rst_status", {14'h0, STATUS_VALID}, {14'h0, status});
    chk("rst_ready", 16'h0001, {15'h0, s_ready});
    rst <= 1'b0;
    cyc(2);
    t_rate(16'h0100, 16'h0000, 16'h0000, 16'h0100, 16'h0100);
    t_rate(16'h0100, 16'h0200, 16'h0000, 16'h0100, 16'h0100);
    t_rate(16'h0100, 16'h0000, 16'h0040, 16'h0200, 16'h0180);
    t_fifo();
    t_st(16'h1500, 1'b1, STATUS_VALID);
    t_st(16'h1A00, 1'b1, STATUS_BAD);
    t_st(16'h1000, 1'b0, STATUS_VALID);
    t_st(16'h0600, 1'b1, STATUS_BAD);
    final_report();
  end
endmodule
